// *** pkg/mftc_pkg.sv ***
// Constants, types and decode functions of the movie frame timing control.
package mftc_pkg;
  localparam int CLK_KHZ = 20000;
  localparam int FRAME_STEP_US = 32500;
  localparam int FRAME_STEP_CYCLES = FRAME_STEP_US * CLK_KHZ / 1000;
  localparam int BLINK_SHORT_MS = 1500;
  localparam int BLINK_LONG_MS = 3000;
  localparam int BLINK_SHORT_CYCLES = BLINK_SHORT_MS * CLK_KHZ;
  localparam int BLINK_LONG_CYCLES = BLINK_LONG_MS * CLK_KHZ;
  localparam int SCAN_RATE_HZ = 430;
  localparam int SCAN_DIGITS = 12;
  localparam int DIGIT_CYCLES = CLK_KHZ * 1000 / (SCAN_RATE_HZ * SCAN_DIGITS);
  localparam logic [7:0] ADDR_FRAME_TIME = 8'h03;
  localparam logic [7:0] ADDR_DISPLAY_OPT = 8'h04;
  localparam logic [7:0] ADDR_LED_CURRENT = 8'h05;
  localparam logic [7:0] RST_FRAME_TIME = 8'h00;
  localparam logic [7:0] RST_DISPLAY_OPT = 8'h20;
  localparam logic [7:0] RST_LED_CURRENT = 8'h00;
  localparam int FT_FADE_BIT = 7;
  localparam int FT_DIR_BIT = 6;
  localparam int FT_BLOCK_BIT = 5;
  localparam int FT_SCROLL_BIT = 4;
  localparam int DO_BLINK_BIT = 4;
  localparam logic [3:0] DELAY_ONCE = 4'h0;
  localparam logic [3:0] DELAY_DOUBLE_CODE = 4'h9;
  localparam logic [2:0] LOOPS_ENDLESS = 3'h7;
  localparam logic [2:0] LOOPS_INVALID = 3'h0;
  localparam logic [3:0] SCAN_MAX = 4'hb;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PLAY = 3'b010,
    ST_DONE = 3'b100
  } mftc_state_type;

  // Code 1001 lands on the same 325 ms as 1010, so it is ten steps, not nine.
  function automatic logic [4:0] mftc_frame_steps(input logic [3:0] code);
    mftc_frame_steps = (code == DELAY_DOUBLE_CODE) ? 5'h0a : {1'b0, code};
  endfunction

  // Limits above column 11 have no columns to add and clamp to all twelve.
  function automatic logic [3:0] mftc_clamp_limit(input logic [3:0] limit);
    mftc_clamp_limit = (limit > SCAN_MAX) ? SCAN_MAX : limit;
  endfunction
endpackage

// *** pkg/mftc_if.sv ***
// Timebase and scan signals shared between the control core and its helpers.
interface mftc_if (
  input wire logic clk,
  input wire logic rst
);
  logic tick_restart;
  logic frame_tick;
  logic blink_long;
  logic blink_phase;
  logic [3:0] scan_limit;
  logic [3:0] col_sel;
  logic sweep_done;

  modport timebase (
    input clk, rst, tick_restart, blink_long,
    output frame_tick, blink_phase
  );
  modport scanner (
    input clk, rst, scan_limit,
    output col_sel, sweep_done
  );
  modport core (
    input frame_tick, blink_phase, col_sel, sweep_done,
    output tick_restart, blink_long, scan_limit
  );
endinterface

// *** src/mftc_timebase.sv ***
// Frame-step tick prescaler and blink phase generator.
module mftc_timebase import mftc_pkg::*; #(
  parameter int TICK_CYCLES = FRAME_STEP_CYCLES,
  parameter int BLINK_SHORT = BLINK_SHORT_CYCLES,
  parameter int BLINK_LONG = BLINK_LONG_CYCLES
) (
  mftc_if.timebase tb
);
  logic [19:0] tick_cnt;
  logic [19:0] next_tick_cnt;
  logic frame_tick;
  logic next_frame_tick;
  logic [25:0] blink_cnt;
  logic [25:0] next_blink_cnt;
  logic blink_phase;
  logic next_blink_phase;
  logic [25:0] half_period;

  always_comb begin
    half_period = tb.blink_long ? 26'(BLINK_LONG / 2 - 1) : 26'(BLINK_SHORT / 2 - 1);
    next_frame_tick = 1'b0;
    next_tick_cnt = tick_cnt + 20'h00001;
    if (tb.tick_restart) begin
      next_tick_cnt = 20'h00000;
    end else if (tick_cnt >= 20'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 20'h00000;
      next_frame_tick = 1'b1;
    end
    next_blink_cnt = blink_cnt + 26'h0000001;
    next_blink_phase = blink_phase;
    if (blink_cnt >= half_period) begin
      next_blink_cnt = 26'h0000000;
      next_blink_phase = ~blink_phase;
    end
  end

  always_ff @(posedge tb.clk or posedge tb.rst) begin
    if (tb.rst) begin
      tick_cnt <= 20'h00000;
      frame_tick <= 1'b0;
      blink_cnt <= 26'h0000000;
      blink_phase <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      frame_tick <= next_frame_tick;
      blink_cnt <= next_blink_cnt;
      blink_phase <= next_blink_phase;
    end
  end

  assign tb.frame_tick = frame_tick;
  assign tb.blink_phase = blink_phase;
endmodule // mftc_timebase

// *** src/mftc_scanner.sv ***
// Column scanner: steps through columns 0 to the scan limit at a fixed digit time.
module mftc_scanner import mftc_pkg::*; (
  mftc_if.scanner sc
);
  logic [11:0] dwell;
  logic [11:0] next_dwell;
  logic [3:0] col;
  logic [3:0] next_col;
  logic sweep;
  logic next_sweep;
  logic [3:0] limit;

  // A fixed time per digit makes the sweep rate rise as the limit falls.
  always_comb begin
    limit = mftc_clamp_limit(sc.scan_limit);
    next_dwell = dwell + 12'h001;
    next_col = col;
    next_sweep = 1'b0;
    if (col > limit) begin
      next_dwell = 12'h000;
      next_col = 4'h0;
      next_sweep = 1'b1;
    end else if (dwell >= 12'(DIGIT_CYCLES - 1)) begin
      next_dwell = 12'h000;
      if (col == limit) begin
        next_col = 4'h0;
        next_sweep = 1'b1;
      end else begin
        next_col = col + 4'h1;
      end
    end
  end

  always_ff @(posedge sc.clk or posedge sc.rst) begin
    if (sc.rst) begin
      dwell <= 12'h000;
      col <= 4'h0;
      sweep <= 1'b0;
    end else begin
      dwell <= next_dwell;
      col <= next_col;
      sweep <= next_sweep;
    end
  end

  assign sc.col_sel = col;
  assign sc.sweep_done = sweep;
endmodule // mftc_scanner

// *** src/mftc_top.sv ***
// Movie frame timing control: settings registers, movie sequencer and display outputs.
module mftc_top import mftc_pkg::*; #(
  parameter int TICK_CYCLES = FRAME_STEP_CYCLES,
  parameter int BLINK_SHORT = BLINK_SHORT_CYCLES,
  parameter int BLINK_LONG = BLINK_LONG_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  input wire logic MOVIE_START,
  input wire logic [5:0] MOVIE_LAST_FRAME,
  input wire logic END_LAST,
  output logic [5:0] FRAME_INDEX,
  output logic FRAME_ADVANCE,
  output logic MOVIE_PLAYING,
  output logic MOVIE_DONE,
  output logic FADE_ENABLE,
  output logic SCROLL_ENABLE,
  output logic SCROLL_LEFT,
  output logic SCROLL_SPLIT,
  output logic SCROLL_STEP,
  output logic [11:0] COLUMN_ENABLE,
  output logic [3:0] COLUMN_SELECT,
  output logic BLINK_PHASE,
  output logic [7:0] LED_CURRENT
);
  mftc_if link (
    .clk(SYS_CLK),
    .rst(RST)
  );

  mftc_timebase #(
    .TICK_CYCLES(TICK_CYCLES),
    .BLINK_SHORT(BLINK_SHORT),
    .BLINK_LONG(BLINK_LONG)
  ) u_timebase (
    .tb(link.timebase)
  );

  mftc_scanner u_scanner (
    .sc(link.scanner)
  );

  // Settings registers.
  logic [7:0] frame_time;
  logic [7:0] next_frame_time;
  logic [7:0] display_opt;
  logic [7:0] next_display_opt;
  logic [7:0] drive_current;
  logic [7:0] next_drive_current;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic wr_frame_time;

  always_comb begin
    wr_frame_time = REG_WR && (REG_ADDR == ADDR_FRAME_TIME);
    next_frame_time = frame_time;
    next_display_opt = display_opt;
    next_drive_current = drive_current;
    if (wr_frame_time) begin
      next_frame_time = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == ADDR_DISPLAY_OPT)) begin
      next_display_opt = REG_WDATA;
    end
    if (REG_WR && (REG_ADDR == ADDR_LED_CURRENT)) begin
      next_drive_current = REG_WDATA;
    end
    case (REG_ADDR)
      ADDR_FRAME_TIME: begin
        next_rdata = frame_time;
      end
      ADDR_DISPLAY_OPT: begin
        next_rdata = display_opt;
      end
      ADDR_LED_CURRENT: begin
        next_rdata = drive_current;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      frame_time <= RST_FRAME_TIME;
      display_opt <= RST_DISPLAY_OPT;
      drive_current <= RST_LED_CURRENT;
      rdata <= 8'h00;
    end else begin
      frame_time <= next_frame_time;
      display_opt <= next_display_opt;
      drive_current <= next_drive_current;
      rdata <= next_rdata;
    end
  end

  // Field views of the settings.
  logic [3:0] delay_code;
  logic [2:0] loops;
  logic [2:0] loop_target;
  logic scroll_on;
  logic split_blocks;

  always_comb begin
    delay_code = frame_time[3:0];
    loops = display_opt[7:5];
    // Code 000 is not valid; it is played as a single loop rather than never ending.
    loop_target = (loops == LOOPS_INVALID) ? 3'h1 : loops;
    scroll_on = frame_time[FT_SCROLL_BIT];
    split_blocks = frame_time[FT_BLOCK_BIT];
  end

  // Movie sequencer.
  mftc_state_type state;
  mftc_state_type next_state;
  logic [5:0] frame_idx;
  logic [5:0] next_frame_idx;
  logic [2:0] loop_cnt;
  logic [2:0] next_loop_cnt;
  logic [4:0] step_cnt;
  logic [4:0] next_step_cnt;
  logic endless;
  logic next_endless;
  logic start_q;
  logic advance;
  logic frame_end;
  logic start_edge;

  always_comb begin
    start_edge = MOVIE_START && !start_q;
    if (delay_code == DELAY_ONCE) begin
      frame_end = link.sweep_done;
    end else begin
      frame_end = link.frame_tick && (step_cnt >= mftc_frame_steps(delay_code) - 5'h01);
    end
    next_state = state;
    next_frame_idx = frame_idx;
    next_loop_cnt = loop_cnt;
    next_step_cnt = step_cnt;
    next_endless = endless;
    advance = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_edge) begin
          next_state = ST_PLAY;
          next_frame_idx = 6'h00;
          next_loop_cnt = 3'h0;
          next_step_cnt = 5'h00;
          next_endless = (loops == LOOPS_ENDLESS);
        end
      end
      ST_PLAY: begin
        if (!MOVIE_START) begin
          next_state = ST_IDLE;
          next_endless = 1'b0;
        end else if (endless && (loops != LOOPS_ENDLESS)) begin
          next_state = ST_DONE;
          next_endless = 1'b0;
        end else if (frame_end) begin
          advance = 1'b1;
          next_step_cnt = 5'h00;
          if (frame_idx < MOVIE_LAST_FRAME) begin
            next_frame_idx = frame_idx + 6'h01;
          end else if (loops == LOOPS_ENDLESS) begin
            next_frame_idx = 6'h00;
            next_endless = 1'b1;
          end else if (3'(loop_cnt + 3'h1) >= loop_target) begin
            next_state = ST_DONE;
            // A scrolling movie that is not told to end on its last frame rests on the first.
            if (scroll_on && !END_LAST) begin
              next_frame_idx = 6'h00;
            end
          end else begin
            next_loop_cnt = loop_cnt + 3'h1;
            next_frame_idx = 6'h00;
          end
        end else if (wr_frame_time) begin
          next_step_cnt = 5'h00;
        end else if (link.frame_tick) begin
          next_step_cnt = step_cnt + 5'h01;
        end
      end
      ST_DONE: begin
        if (!MOVIE_START) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_endless = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      frame_idx <= 6'h00;
      loop_cnt <= 3'h0;
      step_cnt <= 5'h00;
      endless <= 1'b0;
      start_q <= 1'b0;
    end else begin
      state <= next_state;
      frame_idx <= next_frame_idx;
      loop_cnt <= next_loop_cnt;
      step_cnt <= next_step_cnt;
      endless <= next_endless;
      start_q <= MOVIE_START;
    end
  end

  // A timed advance already falls on a prescaler wrap, so restarting there would stretch
  // every frame by one cycle; only sweep-timed frames need the restart on advance.
  assign link.tick_restart = wr_frame_time || start_edge || (advance && (delay_code == DELAY_ONCE));
  assign link.blink_long = display_opt[DO_BLINK_BIT];
  assign link.scan_limit = display_opt[3:0];

  // Display outputs, all registered.
  logic playing;
  logic [11:0] col_mask;
  logic next_fade;
  logic next_scroll;
  logic next_left;
  logic next_split;
  logic next_step;
  logic [11:0] next_col_en;
  logic fade_q;
  logic scroll_q;
  logic left_q;
  logic split_q;
  logic step_q;
  logic advance_q;
  logic [11:0] col_en_q;

  always_comb begin
    playing = (state == ST_PLAY);
    for (int i = 0; i < SCAN_DIGITS; i++) begin
      col_mask[i] = (4'(i) <= mftc_clamp_limit(display_opt[3:0]));
    end
    next_col_en = col_mask;
    // Fading has no room in the split five-LED block layout, so scrolling there forbids it.
    next_fade = playing && frame_time[FT_FADE_BIT] && !(scroll_on && split_blocks);
    next_scroll = playing && scroll_on;
    next_left = frame_time[FT_DIR_BIT];
    next_split = split_blocks;
    next_step = advance && scroll_on;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      fade_q <= 1'b0;
      scroll_q <= 1'b0;
      left_q <= 1'b0;
      split_q <= 1'b0;
      step_q <= 1'b0;
      advance_q <= 1'b0;
      col_en_q <= 12'h001;
    end else begin
      fade_q <= next_fade;
      scroll_q <= next_scroll;
      left_q <= next_left;
      split_q <= next_split;
      step_q <= next_step;
      advance_q <= advance;
      col_en_q <= next_col_en;
    end
  end

  assign REG_RDATA = rdata;
  assign FRAME_INDEX = frame_idx;
  assign FRAME_ADVANCE = advance_q;
  assign MOVIE_PLAYING = (state == ST_PLAY);
  assign MOVIE_DONE = (state == ST_DONE);
  assign FADE_ENABLE = fade_q;
  assign SCROLL_ENABLE = scroll_q;
  assign SCROLL_LEFT = left_q;
  assign SCROLL_SPLIT = split_q;
  assign SCROLL_STEP = step_q;
  assign COLUMN_ENABLE = col_en_q;
  assign COLUMN_SELECT = link.col_sel;
  assign BLINK_PHASE = link.blink_phase;
  assign LED_CURRENT = drive_current;
endmodule // mftc_top

// *** verif/mftc_host.sv ***
// Host model that writes and reads the settings registers and drives movie control.
module mftc_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic start,
  output logic [5:0] last,
  output logic end_last
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    start = 1'b0;
    last = 6'h00;
    end_last = 1'b0;
  end
  // Data is inverted once taken, so a stale byte cannot pass for a fresh one.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    d = rdata;
  endtask
  // Endless play keeps going whatever the end-on-last-frame option; it only picks where a finished scrolling movie rests.
  task automatic movie(input logic s, input logic [5:0] lf, input logic el);
    @(posedge clk);
    last <= lf;
    end_last <= el;
    start <= s;
  endtask
endmodule // mftc_host

// *** verif/mftc_top_chk.sv ***
// Concurrent checks on the ports of the movie frame timing control.
module mftc_top_chk #(
  parameter int BLINK_LONG = 80
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic MOVIE_START,
  input wire logic FRAME_ADVANCE,
  input wire logic MOVIE_PLAYING,
  input wire logic MOVIE_DONE,
  input wire logic FADE_ENABLE,
  input wire logic SCROLL_ENABLE,
  input wire logic SCROLL_SPLIT,
  input wire logic SCROLL_STEP,
  input wire logic [11:0] COLUMN_ENABLE,
  input wire logic [3:0] COLUMN_SELECT,
  input wire logic BLINK_PHASE,
  input wire logic [7:0] LED_CURRENT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  int blink_count;
  int next_blink_count;
  logic last_phase;
  always_comb begin
    next_blink_count = (BLINK_PHASE != last_phase) ? 0 : blink_count + 1;
  end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      blink_count <= 0;
      last_phase <= 1'b0;
    end else begin
      blink_count <= next_blink_count;
      last_phase <= BLINK_PHASE;
    end
  end
  sequence s_opt_write;
    REG_WR && REG_ADDR == 8'h04 ##1 !REG_WR && REG_ADDR == 8'h04;
  endsequence
  a_option_readback: assert property (s_opt_write |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("option register readback differs");
  a_current_write: assert property (REG_WR && REG_ADDR == 8'h05 |=> LED_CURRENT == $past(REG_WDATA))
    else $error("drive current does not follow write");
  a_unmapped_zero: assert property (!(REG_ADDR inside {8'h03, 8'h04, 8'h05}) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_fade_not_split: assert property (FADE_ENABLE |-> !(SCROLL_ENABLE && SCROLL_SPLIT))
    else $error("fade during split block scroll");
  a_step_on_advance: assert property (SCROLL_STEP |-> FRAME_ADVANCE)
    else $error("scroll step without frame change");
  a_advance_spacing: assert property (FRAME_ADVANCE |=> !FRAME_ADVANCE [*8])
    else $error("frame changes too close");
  a_columns_prefix: assert property (COLUMN_ENABLE[0] && ((COLUMN_ENABLE + 12'h001) & COLUMN_ENABLE) == 12'h000)
    else $error("column enables not a prefix");
  a_select_range: assert property (COLUMN_SELECT <= 4'hb)
    else $error("scanned column out of range");
  a_start_plays: assert property ($rose(MOVIE_START) && !MOVIE_PLAYING && !MOVIE_DONE |=> MOVIE_PLAYING)
    else $error("movie did not start");
  a_stop_idles: assert property (MOVIE_PLAYING && !MOVIE_START |=> !MOVIE_PLAYING)
    else $error("movie kept playing after start cleared");
  a_blink_bound: assert property (blink_count <= BLINK_LONG / 2 + 1)
    else $error("blink phase held too long");
endmodule // mftc_top_chk

bind mftc_top mftc_top_chk #(.BLINK_LONG(BLINK_LONG)) chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
  .MOVIE_START(MOVIE_START), .FRAME_ADVANCE(FRAME_ADVANCE), .MOVIE_PLAYING(MOVIE_PLAYING),
  .MOVIE_DONE(MOVIE_DONE), .FADE_ENABLE(FADE_ENABLE), .SCROLL_ENABLE(SCROLL_ENABLE),
  .SCROLL_SPLIT(SCROLL_SPLIT), .SCROLL_STEP(SCROLL_STEP), .COLUMN_ENABLE(COLUMN_ENABLE),
  .COLUMN_SELECT(COLUMN_SELECT), .BLINK_PHASE(BLINK_PHASE), .LED_CURRENT(LED_CURRENT));

// *** verif/tb_top.sv ***
// Self-checking bench for the movie frame timing control.
module tb_top import mftc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICK = 20;
  localparam int BLINK = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata, cur;
  logic wr, start, end_last, adv, play, done, fade, scr, left, split, step, blink;
  logic [5:0] last, idx;
  logic [11:0] cols;
  logic [3:0] sel;
  logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hf};
  int mismatches = 0;
  int compares = 0;
  int seed = 31;
  always #25 clk = ~clk;
  mftc_host h (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .start(start),
    .last(last), .end_last(end_last));
  mftc_top #(.TICK_CYCLES(TICK), .BLINK_SHORT(BLINK), .BLINK_LONG(2 * BLINK)) dut (.SYS_CLK(clk),
    .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RDATA(rdata),
    .MOVIE_START(start), .MOVIE_LAST_FRAME(last), .END_LAST(end_last), .FRAME_INDEX(idx),
    .FRAME_ADVANCE(adv), .MOVIE_PLAYING(play), .MOVIE_DONE(done), .FADE_ENABLE(fade),
    .SCROLL_ENABLE(scr), .SCROLL_LEFT(left), .SCROLL_SPLIT(split), .SCROLL_STEP(step),
    .COLUMN_ENABLE(cols), .COLUMN_SELECT(sel), .BLINK_PHASE(blink), .LED_CURRENT(cur));
  // Code 0 is timed by one scan sweep, which is a single digit at scan limit 0.
  function automatic int gap(input logic [3:0] c);
    return (c == 4'h0) ? DIGIT_CYCLES : ((c == 4'h9) ? 10 : int'(c)) * TICK;
  endfunction
  function automatic logic [11:0] mask(input logic [3:0] n);
    return (n > 4'hb) ? 12'hfff : 12'hfff >> (4'hb - n);
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_adv(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (adv !== 1'b1 && n < lim);
    if (n >= lim) mismatches++;
  endtask
  // The first toggle after a period change may be short, so the second one is timed.
  task automatic blink_gap(output int n);
    logic p;
    p = blink;
    n = 0;
    while (blink === p && n < 200) begin
      @(posedge clk);
      n++;
    end
    p = blink;
    n = 0;
    while (blink === p && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    mismatches++;
    give_verdict();
  end
  initial begin
    logic [7:0] v, r;
    int n, k;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    h.rd_reg(8'h03, v);
    chk("frame reset", 8'h00, v);
    h.rd_reg(8'h04, v);
    chk("option reset", 8'h20, v);
    h.rd_reg(8'h05, v);
    chk("current reset", 8'h00, v);
    h.rd_reg(8'h06, v);
    chk("unmapped read", 8'h00, v);
    chk("columns reset", 12'h001, cols);
    h.wr_reg(8'h04, 8'h30);
    blink_gap(n);
    chk("blink long", BLINK, n);
    h.wr_reg(8'h04, 8'h20);
    blink_gap(n);
    chk("blink short", BLINK / 2, n);
    repeat (4) begin
      r = 8'($random(seed));
      h.wr_reg(8'h05, r);
      h.rd_reg(8'h05, v);
      chk("current", r, v);
      chk("current out", r, cur);
    end
    for (int s = 0; s < 16; s++) begin
      h.wr_reg(8'h04, {3'h1, s[0], s[3:0]});
      @(posedge clk);
      #1 chk("columns", mask(s[3:0]), cols);
    end
    h.wr_reg(8'h04, 8'h20);
    foreach (codes[i]) begin
      r = 8'($random(seed));
      h.wr_reg(8'h03, {r[7:4], codes[i]});
      h.movie(1'b1, 6'd3, 1'b1);
      wait_adv(9000, n);
      wait_adv(9000, n);
      chk("frame gap", gap(codes[i]), n);
      chk("scroll step", r[4], step);
      chk("frame index", 6'd2, idx);
      chk("scroll on", r[4], scr);
      chk("scroll left", r[6], left);
      chk("scroll split", r[5], split);
      chk("fade", r[7] & ~(r[4] & r[5]), fade);
      h.movie(1'b0, 6'd3, 1'b1);
      repeat (3) @(posedge clk);
    end
    h.wr_reg(8'h03, 8'h01);
    for (int l = 1; l < 6; l++) begin
      h.wr_reg(8'h04, {l[2:0], 5'h00});
      h.movie(1'b1, 6'd1, 1'b1);
      n = 0;
      k = 0;
      while (done !== 1'b1 && k < 600) begin
        @(posedge clk);
        k++;
        if (adv === 1'b1) n++;
      end
      chk("loop frames", 2 * l, n);
      chk("loop done", 1'b1, done);
      chk("loop end index", 6'd1, idx);
      h.movie(1'b0, 6'd1, 1'b1);
    end
    h.movie(1'b1, 6'd3, 1'b1);
    wait_adv(900, n);
    repeat (15) @(posedge clk);
    h.wr_reg(8'h03, 8'h01);
    wait_adv(900, n);
    chk("timer restart", TICK + 2, n);
    h.movie(1'b0, 6'd3, 1'b1);
    h.wr_reg(8'h03, 8'h11);
    h.wr_reg(8'h04, 8'he0);
    h.movie(1'b1, 6'd1, 1'b0);
    repeat (300) @(posedge clk);
    chk("endless playing", 1'b1, play);
    h.wr_reg(8'h04, 8'hc0);
    @(posedge clk);
    #1 chk("endless stop", 1'b1, done);
    h.movie(1'b0, 6'd1, 1'b0);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule // tb_top
